// [hdl/l2_read_regs.svh]
/*
  Constants for the level-two read-issue arbiter and hazard check.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef L2_READ_REGS_SVH
`define L2_READ_REGS_SVH
`define AUX_BOOST_BIT     10
`define AUX_RESET_VALUE   32'h0000_0000
`define ADDR_WIDTH        32
`define GRANULE_LSB       5
`define READ_SLOTS        4
`define SLOT_CNT_WIDTH    3
`define STORE_ENTRIES     4
`define QUEUE_DEPTH       4
`define QUEUE_IDX_WIDTH   2
`endif

// [hdl/l2_read_pkg.sv]
/*
  Types shared by the read arbiter and the testbench.
  Assumes the constants header is on the include path.
*/
`include "l2_read_regs.svh"
package l2_read_pkg;
  typedef logic [`ADDR_WIDTH-1:0] addr_type;
  typedef enum logic [1:0] {
    MEM_CACHEABLE = 2'b00,
    MEM_NORMAL_NC = 2'b01,
    MEM_STRONG    = 2'b10,
    MEM_DEVICE    = 2'b11
  } mem_kind_type;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_HOLD  = 2'b10
  } check_state_type;
endpackage : l2_read_pkg

// [hdl/read_queue.sv]
/*
  Small request memory of pending downstream reads, one per slot.
  Read data come out of a register; assumes one clock and async reset.
*/
`timescale 1ns/100ps
`include "l2_read_regs.svh"
module read_queue (
  input  wire logic                    i_mclk,   // Clock
  input  wire logic                    i_nrst,   // Async reset, active low
  input  wire logic                    i_we,     // Write strobe
  input  wire logic [`QUEUE_IDX_WIDTH-1:0] i_waddr, // Write slot
  input  wire logic [`ADDR_WIDTH+1:0]  i_wdata,  // Kind and address
  input  wire logic [`QUEUE_IDX_WIDTH-1:0] i_raddr, // Read slot
  output logic      [`ADDR_WIDTH+1:0]  o_rdata   // Registered read data
);
  logic [`ADDR_WIDTH+1:0] mem [`QUEUE_DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : read_queue

// [hdl/l2_read_priority_hazard_check.sv]
/*
  Read-issue arbiter with store-buffer hazard check for a level-two cache.
  Assumes one clock, upstream valid/ready reads, a store buffer that
  reports its active write granules, and a downstream master that returns
  one completion pulse per issued read.
*/
`timescale 1ns/100ps
`include "l2_read_regs.svh"
// How it works
// - Aux bit 10 enables boost, reset off
// - Boost: strongly-ordered/device reads issue first
// - At most four outstanding downstream reads
// - Misses issue linefills; boosted uncached reads starve them
// - Hazard compare uses address bits 31:5
// - Normal reads checked against active store writes
// - Matching read held until write completes
module l2_read_priority_hazard_check
  import l2_read_pkg::*;
(
  input  wire logic                   i_mclk,      // Clock, 200 MHz
  input  wire logic                   i_nrst,      // Async reset, active low
  input  wire logic                   i_aux_we,    // Aux control write strobe
  input  wire logic [31:0]            i_aux_wdata, // Aux control write data
  input  wire logic                   i_rd_valid,  // Upstream read valid
  input  wire l2_read_pkg::addr_type  i_rd_addr,   // Upstream read address
  input  wire l2_read_pkg::mem_kind_type i_rd_kind, // Memory type
  input  wire logic                   i_rd_hit,    // Cacheable read hits in L2
  input  wire logic [`STORE_ENTRIES-1:0] i_sb_active, // Store entries active
  input  wire logic [`STORE_ENTRIES*`ADDR_WIDTH-1:0] i_sb_addr, // Entry addresses
  input  wire logic                   i_m_ready,   // Downstream takes address
  input  wire logic                   i_m_done,    // One read completed
  output logic                        o_rd_ready,  // Upstream read taken
  output logic                        o_m_valid,   // Downstream address valid
  output l2_read_pkg::addr_type       o_m_addr,    // Downstream address
  output logic                        o_m_linefill, // Request is a linefill
  output logic [31:0]                 o_aux_rdata, // Aux control readback
  output logic [`SLOT_CNT_WIDTH-1:0]  o_slots_used // Outstanding reads
);
  import l2_read_pkg::*;

  function automatic logic same_granule(input addr_type a, input addr_type b);
    same_granule = a[`ADDR_WIDTH-1:`GRANULE_LSB] == b[`ADDR_WIDTH-1:`GRANULE_LSB];
  endfunction : same_granule

  function automatic logic is_uncached_ordered(input mem_kind_type k);
    is_uncached_ordered = (k == MEM_STRONG) || (k == MEM_DEVICE);
  endfunction : is_uncached_ordered

  // Auxiliary control
  logic [31:0] aux, next_aux;
  logic        boost;
  assign boost = aux[`AUX_BOOST_BIT];
  always_comb begin
    next_aux = aux;
    if (i_aux_we) begin
      next_aux = i_aux_wdata;
    end
  end
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      aux <= `AUX_RESET_VALUE;
    end else begin
      aux <= next_aux;
    end
  end

  // Hazard check on intake
  check_state_type state, next_state;
  addr_type        cur_addr, next_cur_addr;
  mem_kind_type    cur_kind, next_cur_kind;
  logic            hazard;
  logic            take, next_rd_ready;
  logic            push;

  always_comb begin
    hazard = 1'b0;
    for (int i = 0; i < `STORE_ENTRIES; i++) begin
      if (i_sb_active[i] && cur_kind != MEM_STRONG && cur_kind != MEM_DEVICE &&
          same_granule(cur_addr, i_sb_addr[i*`ADDR_WIDTH +: `ADDR_WIDTH])) begin
        hazard = 1'b1;
      end
    end
  end

  // Queue of pending reads, arrival ordered
  logic [`QUEUE_DEPTH-1:0]      q_valid, next_q_valid;
  addr_type                     q_addr [`QUEUE_DEPTH];
  mem_kind_type                 q_kind [`QUEUE_DEPTH];
  logic [`QUEUE_IDX_WIDTH-1:0]  q_age  [`QUEUE_DEPTH];
  logic [`QUEUE_IDX_WIDTH-1:0]  wr_slot, sel;
  logic                         sel_ok, q_full;
  logic [`SLOT_CNT_WIDTH-1:0]   used, next_used;
  logic                         issue;
  logic [`ADDR_WIDTH+1:0]       mem_rdata;

  always_comb begin
    wr_slot = '0;
    for (int i = `QUEUE_DEPTH-1; i >= 0; i--) begin
      if (!q_valid[i]) begin
        wr_slot = i[`QUEUE_IDX_WIDTH-1:0];
      end
    end
  end
  assign q_full = &q_valid;

  always_comb begin
    next_state    = state;
    next_cur_addr = cur_addr;
    next_cur_kind = cur_kind;
    take          = 1'b0;
    push          = 1'b0;
    case (state)
      ST_IDLE: begin
        if (i_rd_valid) begin
          take          = 1'b1;
          next_cur_addr = i_rd_addr;
          next_cur_kind = i_rd_kind;
          next_state    = ST_CHECK;
        end
      end
      ST_CHECK, ST_HOLD: begin
        if (hazard) begin
          next_state = ST_HOLD;
        end else if (cur_kind == MEM_CACHEABLE && i_rd_hit && state == ST_CHECK) begin
          next_state = ST_IDLE;
        end else if (!q_full) begin
          push       = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_rd_ready = take;
  end

  // Oldest first; with boost, oldest ordered read beats any miss
  always_comb begin
    sel    = '0;
    sel_ok = 1'b0;
    for (int i = 0; i < `QUEUE_DEPTH; i++) begin
      if (q_valid[i] && (!sel_ok || q_age[i] > q_age[sel])) begin
        if (!(boost && sel_ok && is_uncached_ordered(q_kind[sel]) &&
              !is_uncached_ordered(q_kind[i]))) begin
          sel    = i[`QUEUE_IDX_WIDTH-1:0];
          sel_ok = 1'b1;
        end
      end else if (q_valid[i] && boost && is_uncached_ordered(q_kind[i]) &&
                   !is_uncached_ordered(q_kind[sel])) begin
        sel    = i[`QUEUE_IDX_WIDTH-1:0];
        sel_ok = 1'b1;
      end
    end
  end

  assign issue = sel_ok && (used < `SLOT_CNT_WIDTH'(`READ_SLOTS)) &&
                 (!o_m_valid || i_m_ready);

  always_comb begin
    next_q_valid = q_valid;
    next_used    = used;
    if (issue) begin
      next_q_valid[sel] = 1'b0;
    end
    if (push) begin
      next_q_valid[wr_slot] = 1'b1;
    end
    case ({issue, i_m_done && used != '0})
      2'b10:   next_used = used + `SLOT_CNT_WIDTH'(1);
      2'b01:   next_used = used - `SLOT_CNT_WIDTH'(1);
      default: next_used = used;
    endcase
  end

  read_queue u_queue (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_we    (push),
    .i_waddr (wr_slot),
    .i_wdata ({cur_kind, cur_addr}),
    .i_raddr (sel),
    .o_rdata (mem_rdata)
  );

  // Queue memory must agree with the issued slot one cycle later
  property p_queue_data;
    @(posedge i_mclk) disable iff (!i_nrst)
      issue |=> (mem_rdata == {$past(q_kind[sel]), $past(q_addr[sel])});
  endproperty
  a_queue_data: assert property (p_queue_data) else $error("queue word mismatch");

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state        <= ST_IDLE;
      cur_addr     <= '0;
      cur_kind     <= MEM_CACHEABLE;
      o_rd_ready   <= 1'b0;
      q_valid      <= '0;
      used         <= '0;
      o_m_valid    <= 1'b0;
      o_m_addr     <= '0;
      o_m_linefill <= 1'b0;
      o_aux_rdata  <= '0;
      o_slots_used <= '0;
      for (int i = 0; i < `QUEUE_DEPTH; i++) begin
        q_addr[i] <= '0;
        q_kind[i] <= MEM_CACHEABLE;
        q_age[i]  <= '0;
      end
    end else begin
      state        <= next_state;
      cur_addr     <= next_cur_addr;
      cur_kind     <= next_cur_kind;
      o_rd_ready   <= next_rd_ready;
      q_valid      <= next_q_valid;
      used         <= next_used;
      o_aux_rdata  <= next_aux;
      o_slots_used <= next_used;
      // Age counts younger entries, so ages stay distinct and never saturate
      for (int i = 0; i < `QUEUE_DEPTH; i++) begin
        if (q_valid[i]) begin
          q_age[i] <= q_age[i] + `QUEUE_IDX_WIDTH'(push) -
                      `QUEUE_IDX_WIDTH'(issue && q_age[i] > q_age[sel]);
        end
      end
      if (push) begin
        q_addr[wr_slot] <= cur_addr;
        q_kind[wr_slot] <= cur_kind;
        q_age[wr_slot]  <= '0;
      end
      if (issue) begin
        o_m_valid    <= 1'b1;
        o_m_addr     <= q_addr[sel];
        o_m_linefill <= q_kind[sel] == MEM_CACHEABLE;
      end else if (i_m_ready) begin
        o_m_valid    <= 1'b0;
      end
    end
  end

  // Checks
  property p_slots_bound;
    @(posedge i_mclk) disable iff (!i_nrst) used <= `SLOT_CNT_WIDTH'(`READ_SLOTS);
  endproperty
  a_slots_bound: assert property (p_slots_bound) else $error("more than four reads");
  property p_boost_reset;
    @(posedge i_mclk) disable iff (!i_nrst) $rose(boost) |-> $past(i_aux_we);
  endproperty
  a_boost_reset: assert property (p_boost_reset) else $error("boost set without write");
  property p_hold_hazard;
    @(posedge i_mclk) disable iff (!i_nrst)
      (push && (cur_kind == MEM_CACHEABLE || cur_kind == MEM_NORMAL_NC)) |->
        !((i_sb_active[0] && cur_addr[31:5] == i_sb_addr[31:5]) ||
          (i_sb_active[1] && cur_addr[31:5] == i_sb_addr[63:37]) ||
          (i_sb_active[2] && cur_addr[31:5] == i_sb_addr[95:69]) ||
          (i_sb_active[3] && cur_addr[31:5] == i_sb_addr[127:101]));
  endproperty
  a_hold_hazard: assert property (p_hold_hazard) else $error("hazard read pushed");
  property p_granule;
    @(posedge i_mclk) disable iff (!i_nrst)
      (state != ST_IDLE && (cur_kind == MEM_CACHEABLE || cur_kind == MEM_NORMAL_NC) &&
       i_sb_active[2] && cur_addr[31:5] == i_sb_addr[95:69]) |-> hazard;
  endproperty
  a_granule: assert property (p_granule) else $error("granule match missed");
  property p_normal_check;
    @(posedge i_mclk) disable iff (!i_nrst)
      $rose(state == ST_HOLD) |-> $past(hazard);
  endproperty
  a_normal_check: assert property (p_normal_check) else $error("hold without match");
  property p_boost_prio;
    @(posedge i_mclk) disable iff (!i_nrst)
      (issue && boost && !is_uncached_ordered(q_kind[sel])) |->
        !(|(q_valid & {is_uncached_ordered(q_kind[3]), is_uncached_ordered(q_kind[2]),
                       is_uncached_ordered(q_kind[1]), is_uncached_ordered(q_kind[0])}));
  endproperty
  a_boost_prio: assert property (p_boost_prio) else $error("miss beat ordered read");
  property p_fifo_order;
    @(posedge i_mclk) disable iff (!i_nrst)
      (issue && !boost) |-> (q_valid[0] -> q_age[sel] >= q_age[0]);
  endproperty
  a_fifo_order: assert property (p_fifo_order) else $error("younger read issued");
  property p_linefill;
    @(posedge i_mclk) disable iff (!i_nrst)
      issue |=> (o_m_linefill == ($past(q_kind[sel]) == MEM_CACHEABLE));
  endproperty
  a_linefill: assert property (p_linefill) else $error("linefill flag wrong");
endmodule : l2_read_priority_hazard_check

// [tb/mem_partner.sv]
/*
  Behavioural downstream memory: takes read addresses, returns one
  completion pulse per accepted read. Assumes one clock, async reset.
*/
`timescale 1ns/100ps
module mem_partner (
  input  wire logic i_mclk,  // Clock
  input  wire logic i_nrst,  // Async reset, active low
  input  wire logic i_valid, // Request valid from block
  input  wire logic i_stall, // Withhold address acceptance
  input  wire logic i_keep,  // Withhold completions
  output logic      o_ready, // Address accepted
  output logic      o_done   // One read completed
);
  logic [3:0] pend;
  logic       fire;
  logic       take;
  assign take = i_valid && o_ready;
  assign fire = (pend != 4'h0) && !o_done && !i_keep;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ready <= 1'b0;
      o_done  <= 1'b0;
      pend    <= 4'h0;
    end else begin
      o_ready <= i_valid && !o_ready && !i_stall;
      o_done  <= fire;
      pend    <= pend + {3'h0, take} - {3'h0, fire};
    end
  end
endmodule : mem_partner

// [tb/testbench.sv]
/*
  Self-checking bench for the read arbiter and hazard check.
  Assumes the design package and the downstream partner model.
*/
`timescale 1ns/100ps
module testbench;
  import l2_read_pkg::*;
  logic         mclk = 0, nrst = 0, aux_we = 0, rd_valid = 0, rd_hit = 0;
  logic         stall = 0, keep = 0, m_ready, m_done, rd_ready, m_valid, m_fill;
  logic [31:0]  aux_wdata = 32'h0, aux_rdata;
  addr_type     rd_addr = 32'h0, m_addr;
  mem_kind_type rd_kind = MEM_CACHEABLE;
  logic [3:0]   sb_active = 4'h0;
  logic [127:0] sb_addr = 128'h0;
  logic [2:0]   slots;
  logic [32:0]  q[$];
  int           err_count = 0, checked = 0, cycles = 0;

  always #2.5 mclk = ~mclk;

  l2_read_priority_hazard_check l2_read_priority_hazard_check_i (
    .i_mclk(mclk), .i_nrst(nrst), .i_aux_we(aux_we), .i_aux_wdata(aux_wdata),
    .i_rd_valid(rd_valid), .i_rd_addr(rd_addr), .i_rd_kind(rd_kind),
    .i_rd_hit(rd_hit), .i_sb_active(sb_active), .i_sb_addr(sb_addr),
    .i_m_ready(m_ready), .i_m_done(m_done), .o_rd_ready(rd_ready),
    .o_m_valid(m_valid), .o_m_addr(m_addr), .o_m_linefill(m_fill),
    .o_aux_rdata(aux_rdata), .o_slots_used(slots));

  mem_partner mem_partner_i (
    .i_mclk(mclk), .i_nrst(nrst), .i_valid(m_valid), .i_stall(stall),
    .i_keep(keep), .o_ready(m_ready), .o_done(m_done));

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Records downstream requests, guards the outstanding count, cuts hangs
  always @(posedge mclk) begin
    cycles++;
    if (m_valid === 1'b1 && m_ready === 1'b1) q.push_back({m_fill, m_addr});
    if (nrst && !(slots <= 3'h4)) begin
      err_count++;
      $display("[ERR] slots_used expected <=4 seen %0d", slots);
    end
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic issue(input addr_type a, input mem_kind_type k, input logic h,
                       input int lim, output logic ok);
    ok = 1'b0;
    rd_valid <= 1'b1;
    rd_addr  <= a;
    rd_kind  <= k;
    rd_hit   <= h;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge mclk);
      if (rd_ready === 1'b1) begin
        ok = 1'b1;
        rd_valid <= 1'b0;
      end
    end
    if (ok) @(posedge mclk);
  endtask : issue

  task wait_q(input int n);
    for (int i = 0; i < 60 && q.size() < n; i++) @(posedge mclk);
  endtask : wait_q

  task aux_write(input logic [31:0] v);
    aux_we    <= 1'b1;
    aux_wdata <= v;
    @(posedge mclk);
    aux_we    <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("aux_rdata", {1'b0, v}, {1'b0, aux_rdata});
  endtask : aux_write

  task t_hazard;
    logic ok;
    q.delete();
    sb_addr   <= {32'h0, 32'h1000_0040, 64'h0};
    sb_active <= 4'h4;
    issue(32'h1000_0060, MEM_CACHEABLE, 1'b0, 10, ok);
    wait_q(1);
    chk("other_granule", {1'b1, 32'h1000_0060}, q[0]);
    issue(32'h1000_0048, MEM_STRONG, 1'b0, 10, ok);
    wait_q(2);
    chk("ordered_unchecked", {1'b0, 32'h1000_0048}, q[1]);
    issue(32'h1000_0080, MEM_CACHEABLE, 1'b1, 10, ok);
    issue(32'h1000_005c, MEM_NORMAL_NC, 1'b0, 10, ok);
    repeat (12) @(posedge mclk);
    chk("held_read", 33'h2, 33'(q.size()));
    sb_active <= 4'h0;
    wait_q(3);
    chk("released_read", 33'h3, 33'(q.size()));
    chk("req2", {1'b0, 32'h1000_005c}, q[2]);
  endtask : t_hazard

  task t_order(input logic boost);
    logic ok;
    aux_write({21'h0, boost, 10'h0});
    q.delete();
    stall <= 1'b1;
    issue(32'h2000_0000, MEM_CACHEABLE, 1'b0, 10, ok);
    issue(32'h2000_0100, MEM_CACHEABLE, 1'b0, 10, ok);
    issue(32'h3000_0000, boost ? MEM_STRONG : MEM_DEVICE, 1'b0, 10, ok);
    repeat (6) @(posedge mclk);
    stall <= 1'b0;
    wait_q(3);
    chk("first", {1'b1, 32'h2000_0000}, q[0]);
    chk("second", boost ? {1'b0, 32'h3000_0000} : {1'b1, 32'h2000_0100}, q[1]);
    chk("third", boost ? {1'b1, 32'h2000_0100} : {1'b0, 32'h3000_0000}, q[2]);
    repeat (20) @(posedge mclk);
    chk("drained", 33'h0, {30'h0, slots});
  endtask : t_order

  task t_slots;
    logic ok;
    q.delete();
    keep <= 1'b1;
    for (int i = 0; i < 5; i++)
      issue(addr_type'(32'h4000_0000 + i * 64), MEM_DEVICE, 1'b0, 10, ok);
    repeat (12) @(posedge mclk);
    chk("slots_full", 33'h4, {30'h0, slots});
    chk("issued_full", 33'h4, 33'(q.size()));
    keep <= 1'b0;
    repeat (40) @(posedge mclk);
    chk("slots_drained", 33'h0, {30'h0, slots});
    chk("issued_all", 33'h5, 33'(q.size()));
  endtask : t_slots

  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk("aux_reset", 33'h0, {1'b0, aux_rdata});
    t_hazard();
    t_order(1'b0);
    t_order(1'b1);
    t_slots();
    report_and_stop();
  end
endmodule : testbench
